//--- src/mode_reg_defines.svh
`ifndef MODE_REG_DEFINES_SVH
`define MODE_REG_DEFINES_SVH

// Mode register addresses on the command/address bus
`define MRA_DEVICE_INFO 8'h00
`define MRA_BURST_FEATURE 8'h01
`define MRA_IO_CALIB 8'h0a

// Calibration code that starts the initialization calibration
`define CAL_INIT_CODE 8'hff

// Feature register layout and reset value
`define FEAT_BL_LSB 0
`define FEAT_BT_BIT 3
`define FEAT_WC_BIT 4
`define FEAT_WR_LSB 5
`define FEAT_RESET 8'h22

// Burst length codes
`define BL4_CODE 3'h2
`define BL8_CODE 3'h3
`define BL16_CODE 3'h4

// Write recovery codes and the cycle offset of their encoding
`define WR_CODE_MIN 3'h1
`define WR_CODE_MAX 3'h6
`define WR_CYCLE_OFFSET 4'h2

// Device information fields
`define INFO_INIT_BIT 0
`define INFO_KIND_BIT 1
`define INFO_CAL_LSB 3
`define DEVICE_KIND 1'b0
`define CALCHK_NONE 2'h0
`define CALCHK_VDD 2'h1
`define CALCHK_GND 2'h2
`define CALCHK_PASS 2'h3

`endif

//--- src/mode_reg_pkg.sv
package mode_reg_pkg;

  // Burst engine states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BURST = 3'b010,
    ST_RECOVER = 3'b100
  } burst_state_t;

endpackage

//--- src/mode_reg_burst_ordering.sv
`timescale 1ns/100ps
`include "mode_reg_defines.svh"
// Behaviour
// - Info bit 1 reads zero, device kind
// - Check field: 01 vdd, 10 ground, 11 pass
// - Check field set when init calibration ends
// - Pin tied to supply reports 01
// - On 01/10 factory trim, ignore calibrations
// - Bit 3 selects sequential or interleaved order
// - Bit 4 no-wrap: linear order at every burst length
// - Bits 7:5 codes 1..6 give 3..8 cycles
// - Write auto precharge starts after recovery cycles
// - Four-beat wrap: 0123 or 2301 by C1
// - Eight-beat sequential wraps modulo eight
// - Eight-beat interleaved: index xor start
// - Column bit 0 implied zero
// - Burst address spans 2, 3 or 4 bits
module mode_reg_burst_ordering #(
  parameter int COL_W = 10,
  parameter int INIT_CYCLES = 200,
  parameter int CAL_CYCLES = 64
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mrw_req,
  input wire logic [7:0] mrw_addr,
  input wire logic [7:0] mrw_data,
  input wire logic mrr_req,
  input wire logic [7:0] mrr_addr,
  output logic mrr_ack_q,
  output logic [7:0] mrr_data_q,
  input wire logic zq_at_vdd,
  input wire logic zq_at_gnd,
  input wire logic burst_req,
  input wire logic burst_write,
  input wire logic burst_auto_close,
  input wire logic [COL_W-1:1] burst_col,
  output logic burst_busy_q,
  output logic beat_valid_q,
  output logic [COL_W-1:0] beat_col_q,
  output logic beat_last_q,
  output logic precharge_start_q,
  output logic init_busy_q,
  output logic cal_busy_q,
  output logic factory_trim_q,
  output logic cal_ignored_q
);

  localparam int INIT_W = $clog2(INIT_CYCLES + 1);
  localparam int CAL_W = $clog2(CAL_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Beats in a burst for a length code
  function automatic logic [4:0] beats_of(input logic [2:0] bl);
    logic [4:0] n;
    n = 5'h04;
    if (bl == `BL8_CODE) begin
      n = 5'h08;
    end else if (bl == `BL16_CODE) begin
      n = 5'h10;
    end
    return n;
  endfunction

  // Column of one beat; only the burst address bits move in wrap mode
  function automatic logic [COL_W-1:0] col_of(
    input logic [COL_W-1:0] start,
    input logic [3:0] idx,
    input logic [2:0] bl,
    input logic bt,
    input logic wc
  );
    logic [4:0] nb;
    logic [3:0] mask;
    logic [3:0] low;
    logic [COL_W-1:0] res;
    nb = beats_of(bl);
    mask = nb[3:0] - 4'h1;
    low = bt ? (start[3:0] ^ idx) : (start[3:0] + idx);
    res = {start[COL_W-1:4], (start[3:0] & ~mask) | (low & mask)};
    if (wc) begin
      res = start + COL_W'(idx);
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the calibration pin sense

  logic vdd_s1_q;
  logic vdd_s2_q;
  logic gnd_s1_q;
  logic gnd_s2_q;

  // Two stages, pins are asynchronous to the memory clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vdd_s1_q <= 1'b0;
      vdd_s2_q <= 1'b0;
      gnd_s1_q <= 1'b0;
      gnd_s2_q <= 1'b0;
    end else begin
      vdd_s1_q <= zq_at_vdd;
      vdd_s2_q <= vdd_s1_q;
      gnd_s1_q <= zq_at_gnd;
      gnd_s2_q <= gnd_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Feature register

  logic [7:0] feat_q;
  wire feat_wr = mrw_req && (mrw_addr == `MRA_BURST_FEATURE);
  wire [2:0] new_bl = mrw_data[`FEAT_BL_LSB +: 3];
  wire [2:0] new_wr = mrw_data[`FEAT_WR_LSB +: 3];
  wire bl_ok = (new_bl == `BL4_CODE) || (new_bl == `BL8_CODE) ||
               (new_bl == `BL16_CODE);
  wire wr_ok = (new_wr >= `WR_CODE_MIN) && (new_wr <= `WR_CODE_MAX);
  wire [2:0] cfg_bl = feat_q[`FEAT_BL_LSB +: 3];
  wire cfg_bt = feat_q[`FEAT_BT_BIT];
  wire cfg_wc = feat_q[`FEAT_WC_BIT];
  wire [3:0] cfg_wr = {1'b0, feat_q[`FEAT_WR_LSB +: 3]} + `WR_CYCLE_OFFSET;

  // Reserved length or recovery codes leave that field as it was
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      feat_q <= `FEAT_RESET;
    end else if (feat_wr) begin
      feat_q[`FEAT_BL_LSB +: 3] <= bl_ok ? new_bl : cfg_bl;
      feat_q[`FEAT_BT_BIT] <= mrw_data[`FEAT_BT_BIT];
      feat_q[`FEAT_WC_BIT] <= mrw_data[`FEAT_WC_BIT];
      feat_q[`FEAT_WR_LSB +: 3] <= wr_ok ? new_wr : feat_q[`FEAT_WR_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Auto initialization and calibration

  logic [INIT_W-1:0] init_cnt_q;
  logic [CAL_W-1:0] cal_cnt_q;
  logic cal_init_q;
  logic [1:0] calchk_q;
  wire cal_cmd = mrw_req && (mrw_addr == `MRA_IO_CALIB);
  wire cal_start = cal_cmd && !cal_busy_q && !factory_trim_q;
  wire cal_done = cal_busy_q && (cal_cnt_q == '0);
  wire [1:0] pin_result = vdd_s2_q ? `CALCHK_VDD :
                          gnd_s2_q ? `CALCHK_GND : `CALCHK_PASS;

  // init counter runs out after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_busy_q <= 1'b1;
      init_cnt_q <= INIT_W'(INIT_CYCLES - 1);
    end else if (init_busy_q) begin
      init_cnt_q <= init_cnt_q - 1'b1;
      init_busy_q <= (init_cnt_q != '0);
    end
  end

  // Commands arriving mid-calibration are dropped and flagged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_busy_q <= 1'b0;
      cal_cnt_q <= '0;
      cal_init_q <= 1'b0;
      calchk_q <= `CALCHK_NONE;
      factory_trim_q <= 1'b0;
      cal_ignored_q <= 1'b0;
    end else begin
      // no new calibration once on factory trim
      cal_ignored_q <= cal_cmd && !cal_start;
      if (cal_start) begin
        cal_busy_q <= 1'b1;
        cal_cnt_q <= CAL_W'(CAL_CYCLES - 1);
        cal_init_q <= (mrw_data == `CAL_INIT_CODE);
      end else if (cal_done) begin
        cal_busy_q <= 1'b0;
        // field updated by the init calibration
        if (cal_init_q) begin
          calchk_q <= pin_result;
          // assembly error falls back to trim
          factory_trim_q <= (pin_result != `CALCHK_PASS);
        end
      end else if (cal_busy_q) begin
        cal_cnt_q <= cal_cnt_q - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode register read

  wire [7:0] info_word = {3'h0, calchk_q, 1'b0, `DEVICE_KIND, init_busy_q};
  wire [7:0] read_word = (mrr_addr == `MRA_DEVICE_INFO) ? info_word : 8'h00;

  // Write-only and unused addresses read back zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mrr_ack_q <= 1'b0;
      mrr_data_q <= 8'h00;
    end else begin
      mrr_ack_q <= mrr_req;
      mrr_data_q <= mrr_req ? read_word : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst column sequencer

  mode_reg_pkg::burst_state_t state_q;
  logic [COL_W-1:0] start_q;
  logic [3:0] idx_q;
  logic [2:0] bl_q;
  logic bt_q;
  logic wc_q;
  logic close_q;
  logic [3:0] rec_len_q;
  logic [3:0] rec_cnt_q;
  wire idle = (state_q == mode_reg_pkg::ST_IDLE);
  wire accept = burst_req && idle && !init_busy_q;
  wire last_beat = ({1'b0, idx_q} == beats_of(bl_q) - 5'h01);
  wire [COL_W-1:0] next_col = col_of(start_q, idx_q, bl_q, bt_q, wc_q);

  // Settings are frozen at accept, so a mid-burst write is harmless
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= mode_reg_pkg::ST_IDLE;
      start_q <= '0;
      idx_q <= 4'h0;
      bl_q <= `BL4_CODE;
      bt_q <= 1'b0;
      wc_q <= 1'b0;
      close_q <= 1'b0;
      rec_len_q <= 4'h0;
      rec_cnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        mode_reg_pkg::ST_IDLE: begin
          if (accept) begin
            state_q <= mode_reg_pkg::ST_BURST;
            // low column bit forced to zero
            start_q <= {burst_col, 1'b0};
            idx_q <= 4'h0;
            bl_q <= cfg_bl;
            bt_q <= cfg_bt;
            wc_q <= cfg_wc;
            close_q <= burst_write && burst_auto_close;
            rec_len_q <= cfg_wr;
          end
        end
        mode_reg_pkg::ST_BURST: begin
          idx_q <= idx_q + 4'h1;
          if (last_beat) begin
            rec_cnt_q <= rec_len_q - 4'h1;
            state_q <= close_q ? mode_reg_pkg::ST_RECOVER :
                                 mode_reg_pkg::ST_IDLE;
          end
        end
        mode_reg_pkg::ST_RECOVER: begin
          rec_cnt_q <= rec_cnt_q - 4'h1;
          if (rec_cnt_q == 4'h0) begin
            state_q <= mode_reg_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Registered beat outputs, one column per clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beat_valid_q <= 1'b0;
      beat_col_q <= '0;
      beat_last_q <= 1'b0;
      precharge_start_q <= 1'b0;
      burst_busy_q <= 1'b0;
    end else begin
      burst_busy_q <= !idle || accept;
      beat_valid_q <= (state_q == mode_reg_pkg::ST_BURST);
      beat_last_q <= (state_q == mode_reg_pkg::ST_BURST) && last_beat;
      if (state_q == mode_reg_pkg::ST_BURST) begin
        beat_col_q <= next_col;
      end
      precharge_start_q <= (state_q == mode_reg_pkg::ST_RECOVER) &&
                           (rec_cnt_q == 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic [3:0] gap_q;

  // Cycles since the last beat, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 4'h0;
    end else if (beat_last_q) begin
      gap_q <= 4'h1;
    end else if (gap_q != 4'hf) begin
      gap_q <= gap_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_info_read: assert property (
    mrr_req && mrr_addr == `MRA_DEVICE_INFO |=> mrr_ack_q &&
    mrr_data_q[1] == 1'b0 && mrr_data_q[0] == $past(init_busy_q))
    else $error("device information bits wrong");

  a_cal_update: assert property (
    cal_done && cal_init_q |=> calchk_q != `CALCHK_NONE)
    else $error("check field not updated after calibration");

  a_cal_vdd: assert property (
    cal_done && cal_init_q && vdd_s2_q |=> calchk_q == `CALCHK_VDD &&
    factory_trim_q)
    else $error("supply-tied pin not reported as 01");

  a_trim_ignore: assert property (
    factory_trim_q && cal_cmd |=> cal_ignored_q && !cal_busy_q)
    else $error("calibration accepted on factory trim");

  a_len_eight: assert property (
    accept && cfg_bl == `BL8_CODE |=> ##1 beat_valid_q [*8] ##1
    !beat_valid_q)
    else $error("eight-beat burst length wrong");

  a_wrap_four: assert property (
    accept && cfg_bl == `BL4_CODE && !cfg_wc && burst_col[1] |=> ##1
    beat_col_q[1:0] == 2'h2 ##1 beat_col_q[1:0] == 2'h3 ##1
    beat_col_q[1:0] == 2'h0 ##1 beat_col_q[1:0] == 2'h1)
    else $error("four-beat wrap order wrong");

  a_seq_eight: assert property (
    accept && cfg_bl == `BL8_CODE && !cfg_bt && burst_col[2:1] == 2'h3
    |=> ##1 beat_col_q[2:0] == 3'h6 ##1 beat_col_q[2:0] == 3'h7 ##1
    beat_col_q[2:0] == 3'h0 ##1 beat_col_q[3] == $past(beat_col_q[3]))
    else $error("eight-beat sequential order wrong");

  a_int_eight: assert property (
    accept && cfg_bl == `BL8_CODE && cfg_bt && burst_col[2:1] == 2'h3
    |=> ##1 beat_col_q[2:0] == 3'h6 ##1 beat_col_q[2:0] == 3'h7 ##1
    beat_col_q[2:0] == 3'h4 ##1 beat_col_q[2:0] == 3'h5)
    else $error("eight-beat interleaved order wrong");

  a_nowrap_four: assert property (
    accept && cfg_bl == `BL4_CODE && cfg_wc |=> ##1
    beat_col_q == $past({burst_col, 1'b0}, 2) ##3
    beat_col_q == $past({burst_col, 1'b0}, 5) + COL_W'(3))
    else $error("no-wrap order not linear");

  a_recovery_gap: assert property (
    precharge_start_q |-> gap_q == rec_len_q)
    else $error("precharge not after recovery cycles");

endmodule

//--- test/ctrl_model.sv
`timescale 1ns/100ps
// Controller stand-in; drives the command side at falling edges
module ctrl_model #(
  parameter int COL_W = 10
) (
  input wire logic clk,
  output logic mrw_req,
  output logic [7:0] mrw_addr,
  output logic [7:0] mrw_data,
  output logic mrr_req,
  output logic [7:0] mrr_addr,
  input wire logic mrr_ack_q,
  input wire logic [7:0] mrr_data_q,
  output logic burst_req,
  output logic burst_write,
  output logic burst_auto_close,
  output logic [COL_W-1:1] burst_col
);
  // Quiet bus at time zero
  initial begin
    {mrw_req, mrr_req, burst_req, burst_write, burst_auto_close} = 5'h00;
    {mrw_addr, mrw_data, mrr_addr} = 24'h000000;
    burst_col = '0;
  end
  // caller may pass reserved codes; the task does not check them
  // Released lines flip so a stale value never looks valid
  task automatic mrw(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {mrw_req, mrw_addr, mrw_data} = {1'b1, a, d};
    @(negedge clk);
    {mrw_req, mrw_addr, mrw_data} = {1'b0, ~a, ~d};
  endtask
  // Read answer taken in its only valid cycle
  task automatic mrr(input logic [7:0] a, output logic ack,
                     output logic [7:0] d);
    @(negedge clk);
    {mrr_req, mrr_addr} = {1'b1, a};
    @(negedge clk);
    {mrr_req, mrr_addr} = {1'b0, ~a};
    ack = mrr_ack_q;
    d = mrr_data_q;
  endtask
  task automatic burst(input logic [COL_W-1:1] c, input logic w,
                       input logic ac);
    @(negedge clk);
    {burst_req, burst_col, burst_write, burst_auto_close} = {1'b1, c, w, ac};
    @(negedge clk);
    {burst_req, burst_col, burst_write, burst_auto_close} = {1'b0, ~c, ~w, ~ac};
  endtask
endmodule

//--- test/mode_reg_burst_ordering_tb.sv
`timescale 1ns/100ps
`define CHECK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("mismatch at %0t: got %h want %h", $time, got, exp); \
  end \
end
`define WAIT_LOW(s) for (int k = 0; k < 300 && s !== 1'b0; k++) @(negedge clk);
module mode_reg_burst_ordering_tb;
  logic clk, rst_n, zq_at_vdd, zq_at_gnd;
  logic mrw_req, mrr_req, mrr_ack_q, burst_req, burst_write, burst_auto_close;
  logic [7:0] mrw_addr, mrw_data, mrr_addr, mrr_data_q;
  logic [9:1] burst_col;
  logic burst_busy_q, beat_valid_q, beat_last_q, precharge_start_q;
  logic init_busy_q, cal_busy_q, factory_trim_q, cal_ignored_q;
  logic [9:0] beat_col_q;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  mode_reg_burst_ordering #(.COL_W(10), .INIT_CYCLES(8), .CAL_CYCLES(4))
    i_mode_reg_burst_ordering (.*);
  ctrl_model #(.COL_W(10)) i_ctrl_model (.clk(clk), .mrw_req(mrw_req),
    .mrw_addr(mrw_addr), .mrw_data(mrw_data), .mrr_req(mrr_req),
    .mrr_addr(mrr_addr), .mrr_ack_q(mrr_ack_q), .mrr_data_q(mrr_data_q),
    .burst_req(burst_req), .burst_write(burst_write),
    .burst_auto_close(burst_auto_close), .burst_col(burst_col));
  // Clock and run limit; a hang ends in the same report
  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Register read with its answer judged
  task automatic chk_mr(input logic [7:0] a, input logic [7:0] e);
    logic ack;
    logic [7:0] d;
    i_ctrl_model.mrr(a, ack, d);
    `CHECK(ack, 1'b1)
    `CHECK(d, e)
  endtask
  // Column order from start, length, type and wrap
  function automatic logic [9:0] exp_col(logic [7:0] c, logic [9:0] s, int i);
    logic [9:0] m;
    m = (c[2:0] == 3'h2) ? 10'h003 : (c[2:0] == 3'h3) ? 10'h007 : 10'h00f;
    if (c[4]) return s + 10'(i);
    if (c[3]) return (s & ~m) | ((s ^ 10'(i)) & m);
    return (s & ~m) | ((s + 10'(i)) & m);
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Reset, init status, one or two calibrations under a pin condition
  task automatic t_calib(input logic v, input logic g, input logic [1:0] e);
    logic trim;
    trim = (e != 2'h3);
    {zq_at_vdd, zq_at_gnd, rst_n} = {v, g, 1'b0};
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk_mr(8'h00, 8'h01);
    chk_mr(8'h05, 8'h00);
    i_ctrl_model.burst(9'h000, 1'b0, 1'b0);
    `CHECK(burst_busy_q, 1'b0)
    `WAIT_LOW(init_busy_q)
    chk_mr(8'h00, 8'h00);
    i_ctrl_model.mrw(8'h0a, 8'hff);
    `WAIT_LOW(cal_busy_q)
    chk_mr(8'h00, {3'h0, e, 3'h0});
    `CHECK(factory_trim_q, trim)
    i_ctrl_model.mrw(8'h0a, 8'hff);
    `CHECK(cal_ignored_q, trim)
    `CHECK(cal_busy_q, ~trim)
    `WAIT_LOW(cal_busy_q)
  endtask
  // Program, run one burst, judge each beat and the precharge moment
  task automatic t_burst(input logic [7:0] wd, input logic [7:0] c,
                         input logic [9:0] s, input logic w, input logic ac);
    int len;
    int n;
    len = 4 << (int'(c[2:0]) - 2);
    n = int'(c[7:5]) + 2;
    i_ctrl_model.mrw(8'h01, wd);
    i_ctrl_model.burst(s[9:1], w, ac);
    `CHECK(burst_busy_q, 1'b1)
    for (int k = 0; k < 4 && beat_valid_q !== 1'b1; k++) @(negedge clk);
    for (int i = 0; i < len; i++) begin
      `CHECK(beat_valid_q, 1'b1)
      `CHECK(beat_col_q, exp_col(c, s, i))
      `CHECK(beat_last_q, 1'(i == len - 1))
      @(negedge clk);
    end
    for (int j = 1; j <= n; j++) begin
      `CHECK(precharge_start_q, 1'(w && ac && j == n))
      if (j < n) @(negedge clk);
    end
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, zq_at_vdd, zq_at_gnd} = 3'h0;
    t_calib(1'b0, 1'b0, 2'h3);
    t_burst(8'h22, 8'h22, 10'h00a, 1'b0, 1'b0);
    t_burst(8'h2a, 8'h2a, 10'h002, 1'b1, 1'b1);
    t_burst(8'h23, 8'h23, 10'h0f6, 1'b0, 1'b1);
    for (int s = 0; s < 8; s += 2) begin
      t_burst(8'h2b, 8'h2b, 10'h100 | 10'(s), 1'b0, 1'b0);
    end
    t_burst(8'h32, 8'h32, 10'h01e, 1'b0, 1'b0);
    t_burst(8'h24, 8'h24, 10'h03a, 1'b0, 1'b0);
    t_burst(8'hc3, 8'hc3, 10'h000, 1'b1, 1'b1);
    // Reserved length and recovery codes keep their old values
    t_burst(8'hef, 8'hcb, 10'h004, 1'b1, 1'b1);
    t_calib(1'b1, 1'b0, 2'h1);
    t_calib(1'b0, 1'b1, 2'h2);
    report_and_stop();
  end
endmodule
